// file: core/pdc_device_control.v
// Device control register with size limits and error message gating
// Functional notes
// - Bit 15 reserved, always reads zero
// - Bits 14:12 max read request size code
// - Read fetch combines request limit, cache line
// - Bits 7:5 max payload size code
// - No-snoop enable bit reads zero
// - Aux power PM enable bit reads zero
// - Phantom function enable bit reads zero
// - Extended tag enable bit reads zero
// - Relaxed ordering enable bit reads zero
// - Unsupported request sends nonfatal when enabled
// - Fatal event sends fatal message when enabled
// - Nonfatal event sends nonfatal message when enabled
// - Correctable event sends correctable message when enabled
// - Register at 98h, resets to 2000h
`timescale 1ns/100ps
`include "pdc_defines.vh"

module pdc_device_control #(
  parameter LEN_W = `PDC_LEN_W,
  parameter CLS_W = `PDC_CLS_W
) (
  input  wire                   clk_in,
  input  wire                   nrst_in,
  input  wire                   cfg_wr_in,
  input  wire                   cfg_rd_in,
  input  wire [`PDC_ADDR_W-1:0] cfg_addr_in,
  input  wire [1:0]             cfg_be_in,
  input  wire [15:0]            cfg_wdata_in,
  output reg  [15:0]            cfg_rdata_out,
  output reg                    cfg_rvalid_out,
  input  wire                   ur_event_in,
  input  wire                   fatal_event_in,
  input  wire                   nonfatal_event_in,
  input  wire                   corr_event_in,
  output reg                    msg_err_fatal_out,
  output reg                    msg_err_nonfatal_out,
  output reg                    msg_err_corr_out,
  input  wire [CLS_W-1:0]       cache_line_size_in,
  input  wire                   read_req_in,
  input  wire [LEN_W-1:0]       read_len_in,
  output reg                    fetch_valid_out,
  output reg  [LEN_W-1:0]       fetch_len_out,
  output reg  [LEN_W-1:0]       max_read_request_bytes_out,
  output reg  [LEN_W-1:0]       max_payload_bytes_out
);

  // Reserved codes fall back to the smallest size so traffic never overruns a partner
  function [LEN_W-1:0] size_bytes;
    input [2:0] code;
    begin
      if (code > `PDC_SIZE_MAX_CODE)
        size_bytes = `PDC_SIZE_BASE;
      else
        size_bytes = `PDC_SIZE_BASE << code;
    end
  endfunction

  reg  [2:0]       max_read_request_size;
  reg  [2:0]       max_payload_size;
  reg              unsupported_request_report_enable;
  reg              fatal_error_report_enable;
  reg              nonfatal_error_report_enable;
  reg              correctable_error_report_enable;
  reg  [15:0]      devctl_view;
  reg  [15:0]      next_devctl;
  reg  [LEN_W:0]   cl_bytes;
  reg  [LEN_W:0]   rounded_len;
  reg  [LEN_W-1:0] next_fetch_len;
  wire             hit;
  wire [15:0]      byte_mask;
  wire [LEN_W-1:0] rdreq_bytes;

  assign hit         = (cfg_addr_in == `PDC_DEVCTL_OFFSET);
  assign byte_mask   = {{8{cfg_be_in[1]}}, {8{cfg_be_in[0]}}};
  assign rdreq_bytes = size_bytes(max_read_request_size);

  // Fixed and reserved bits are constant zero in the read view
  always @*
  begin
    devctl_view = 16'h0000;
    devctl_view[`PDC_RDREQ_HI:`PDC_RDREQ_LO]     = max_read_request_size;
    devctl_view[`PDC_PAYLOAD_HI:`PDC_PAYLOAD_LO] = max_payload_size;
    devctl_view[`PDC_UR_REPORT_BIT]    = unsupported_request_report_enable;
    devctl_view[`PDC_FATAL_REPORT_BIT] = fatal_error_report_enable;
    devctl_view[`PDC_NONFATAL_REP_BIT] = nonfatal_error_report_enable;
    devctl_view[`PDC_CORR_REPORT_BIT]  = correctable_error_report_enable;
    next_devctl = (devctl_view & ~(byte_mask & `PDC_DEVCTL_WMASK))
                | (cfg_wdata_in & byte_mask & `PDC_DEVCTL_WMASK);
  end

  // Cache line size counts dwords; a power of two is assumed for the round-up mask
  always @*
  begin
    cl_bytes    = {{(LEN_W+1-CLS_W-2){1'b0}}, cache_line_size_in, `PDC_DWORD_SHIFT};
    rounded_len = {1'b0, read_len_in};
    if (cl_bytes != {(LEN_W+1){1'b0}})
      rounded_len = ({1'b0, read_len_in} + cl_bytes - {{LEN_W{1'b0}}, 1'b1})
                  & ~(cl_bytes - {{LEN_W{1'b0}}, 1'b1});
    if (rounded_len > {1'b0, rdreq_bytes})
      next_fetch_len = rdreq_bytes;
    else
      next_fetch_len = rounded_len[LEN_W-1:0];
  end

  always @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      max_read_request_size             <= `PDC_RDREQ_RESET;
      max_payload_size                  <= `PDC_PAYLOAD_RESET;
      unsupported_request_report_enable <= 1'b0;
      fatal_error_report_enable         <= 1'b0;
      nonfatal_error_report_enable      <= 1'b0;
      correctable_error_report_enable   <= 1'b0;
      cfg_rdata_out                     <= 16'h0000;
      cfg_rvalid_out                    <= 1'b0;
    end
    else
    begin
      if (cfg_wr_in && hit)
      begin
        max_read_request_size             <= next_devctl[`PDC_RDREQ_HI:`PDC_RDREQ_LO];
        max_payload_size                  <= next_devctl[`PDC_PAYLOAD_HI:`PDC_PAYLOAD_LO];
        unsupported_request_report_enable <= next_devctl[`PDC_UR_REPORT_BIT];
        fatal_error_report_enable         <= next_devctl[`PDC_FATAL_REPORT_BIT];
        nonfatal_error_report_enable      <= next_devctl[`PDC_NONFATAL_REP_BIT];
        correctable_error_report_enable   <= next_devctl[`PDC_CORR_REPORT_BIT];
      end
      cfg_rvalid_out <= cfg_rd_in;
      if (cfg_rd_in)
        cfg_rdata_out <= hit ? devctl_view : 16'h0000;
    end
  end

  // Enables only gate messages; detection and logging live in the status block
  always @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      msg_err_fatal_out          <= 1'b0;
      msg_err_nonfatal_out       <= 1'b0;
      msg_err_corr_out           <= 1'b0;
      fetch_valid_out            <= 1'b0;
      fetch_len_out              <= {LEN_W{1'b0}};
      max_read_request_bytes_out <= `PDC_RDREQ_RESET_BYTES;
      max_payload_bytes_out      <= `PDC_PAYLOAD_RST_BYTES;
    end
    else
    begin
      msg_err_fatal_out    <= fatal_event_in & fatal_error_report_enable;
      msg_err_nonfatal_out <= (ur_event_in & unsupported_request_report_enable)
                            | (nonfatal_event_in & nonfatal_error_report_enable);
      msg_err_corr_out     <= corr_event_in & correctable_error_report_enable;
      fetch_valid_out      <= read_req_in;
      if (read_req_in)
        fetch_len_out <= next_fetch_len;
      max_read_request_bytes_out <= rdreq_bytes;
      max_payload_bytes_out      <= size_bytes(max_payload_size);
    end
  end

endmodule // pdc_device_control

// file: inc/pdc_defines.vh
// Constants for the device control register block
`ifndef PDC_DEFINES_VH
`define PDC_DEFINES_VH
`define PDC_ADDR_W        12
`define PDC_DEVCTL_OFFSET 12'h098
`define PDC_DEVCTL_RESET  16'h2000
`define PDC_DEVCTL_WMASK  16'h70ef
`define PDC_RDREQ_HI          14
`define PDC_RDREQ_LO          12
`define PDC_PAYLOAD_HI        7
`define PDC_PAYLOAD_LO        5
`define PDC_UR_REPORT_BIT     3
`define PDC_FATAL_REPORT_BIT  2
`define PDC_NONFATAL_REP_BIT  1
`define PDC_CORR_REPORT_BIT   0
`define PDC_RDREQ_RESET       3'h2
`define PDC_PAYLOAD_RESET     3'h0
`define PDC_RDREQ_RESET_BYTES 13'h0200
`define PDC_PAYLOAD_RST_BYTES 13'h0080
`define PDC_DWORD_SHIFT       2'b00
`define PDC_SIZE_MAX_CODE 3'h5
`define PDC_SIZE_BASE     13'h0080
`define PDC_LEN_W         13
`define PDC_CLS_W         8
`endif

// file: test/pdc_device_control_properties.sv
// Port assertions for the device control register
`timescale 1ns/100ps
module pdc_device_control_chk #(parameter LEN_W = 13) (
  input wire clk_in, nrst_in, cfg_rd_in, cfg_rvalid_out, read_req_in, fetch_valid_out,
  input wire [15:0] cfg_rdata_out,
  input wire ur_event_in, fatal_event_in, nonfatal_event_in, corr_event_in,
  input wire msg_err_fatal_out, msg_err_nonfatal_out, msg_err_corr_out,
  input wire [LEN_W-1:0] fetch_len_out, max_read_request_bytes_out, max_payload_bytes_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  rd_answer_a: assert property (cfg_rd_in |=> cfg_rvalid_out)
    else $error("read not answered");
  fixed_bits_a: assert property (cfg_rvalid_out |-> !(cfg_rdata_out & 16'h8f10))
    else $error("fixed bit reads one");
  fatal_msg_a: assert property (msg_err_fatal_out |-> $past(fatal_event_in))
    else $error("fatal message without event");
  nonfatal_msg_a: assert property (msg_err_nonfatal_out |-> $past(ur_event_in | nonfatal_event_in))
    else $error("nonfatal message without event");
  corr_msg_a: assert property (msg_err_corr_out |-> $past(corr_event_in))
    else $error("correctable message without event");
  fetch_size_a: assert property (read_req_in |=> fetch_valid_out && fetch_len_out <= 13'h1000)
    else $error("fetch answer missing");
  read_limit_a: assert property ($onehot(max_read_request_bytes_out) && max_read_request_bytes_out >= 13'h0080)
    else $error("read limit not a size");
  payload_limit_a: assert property ($onehot(max_payload_bytes_out) && max_payload_bytes_out >= 13'h0080)
    else $error("payload limit not a size");
  reset_limits_a: assert property ($rose(nrst_in) |-> max_read_request_bytes_out == 13'h0200)
    else $error("read limit after reset");
endmodule // pdc_device_control_chk

// file: test/pdc_root_model.sv
// Root complex model counting error messages, four bits per kind
`timescale 1ns/100ps
module pdc_root_model (
  input  wire        clk_in,
  input  wire [2:0]  msg_in,
  output reg  [11:0] cnt_out
);
  initial cnt_out = 12'h000;
  always @(posedge clk_in) cnt_out <= cnt_out + {3'h0, msg_in[2], 3'h0, msg_in[1], 3'h0, msg_in[0]};
endmodule // pdc_root_model

// file: test/tb_pdc_device_control.sv
// Testbench for the device control register
`timescale 1ns/100ps
module tb_pdc_device_control;
  reg clk_in = 0, nrst_in = 0, cfg_wr_in = 0, cfg_rd_in = 0, read_req_in = 0;
  reg ur_event_in = 0, fatal_event_in = 0, nonfatal_event_in = 0, corr_event_in = 0;
  reg [11:0] cfg_addr_in = 0;
  reg [1:0] cfg_be_in = 0;
  reg [15:0] cfg_wdata_in = 0;
  reg [7:0] cache_line_size_in = 8'h10;
  reg [12:0] read_len_in = 0;
  reg [3:0] v;
  wire [15:0] cfg_rdata_out;
  wire cfg_rvalid_out, msg_err_fatal_out, msg_err_nonfatal_out, msg_err_corr_out, fetch_valid_out;
  wire [12:0] fetch_len_out, max_read_request_bytes_out, max_payload_bytes_out;
  wire [11:0] cnt;
  integer bad_count = 0, tests_run = 0, cyc = 0, i, e;
  always #10 clk_in = ~clk_in;
  pdc_device_control i_pdc_device_control (.*);
  pdc_root_model i_pdc_root_model (.clk_in(clk_in), .cnt_out(cnt),
    .msg_in({msg_err_fatal_out, msg_err_nonfatal_out, msg_err_corr_out}));
  task chk(input [15:0] got, input [15:0] exp);
    tests_run++;
    if (got !== exp) $display("BAD at %0t got %h exp %h", $time, got, exp);
    if (got !== exp) bad_count++;
  endtask
  task wr(input [11:0] a, input [1:0] b, input [15:0] d);
    @(posedge clk_in); cfg_wr_in <= 1; cfg_addr_in <= a; cfg_be_in <= b; cfg_wdata_in <= d;
    @(posedge clk_in); cfg_wr_in <= 0;
  endtask
  task rd(input [11:0] a, input [15:0] exp);
    @(posedge clk_in); cfg_rd_in <= 1; cfg_addr_in <= a;
    @(posedge clk_in); cfg_rd_in <= 0;
    #1 chk(cfg_rvalid_out, 1);
    chk(cfg_rdata_out, exp);
  endtask
  task ev(input [3:0] s, input [2:0] exp);
    @(posedge clk_in); {ur_event_in, fatal_event_in, nonfatal_event_in, corr_event_in} <= s;
    @(posedge clk_in); {ur_event_in, fatal_event_in, nonfatal_event_in, corr_event_in} <= 0;
    #1 chk({msg_err_fatal_out, msg_err_nonfatal_out, msg_err_corr_out}, exp);
  endtask
  task fetch(input [12:0] len, input [12:0] exp);
    @(posedge clk_in); read_req_in <= 1; read_len_in <= len;
    @(posedge clk_in); read_req_in <= 0;
    #1 chk(fetch_valid_out, 1);
    chk(fetch_len_out, exp);
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Hang guard, the whole run needs under a hundred cycles
  always @(posedge clk_in) if (++cyc == 3000) begin bad_count++; give_verdict; end
  initial
  begin
    repeat (6) @(posedge clk_in);
    nrst_in <= 1;
    #1 chk(max_payload_bytes_out, 13'h0080);
    rd(12'h098, 16'h2000);
    wr(12'h098, 2'h3, 16'hffff); rd(12'h098, 16'h70ef);
    wr(12'h098, 2'h3, 0); wr(12'h098, 2'h1, 16'hffff); rd(12'h098, 16'h00ef);
    wr(12'h09a, 2'h3, 16'hffff); rd(12'h09a, 0); rd(12'h098, 16'h00ef);
    $display("register access test done");
    for (i = 0; i < 8; i++)
    begin
      wr(12'h098, 2'h3, (i << 12) | (i << 5)); rd(12'h098, (i << 12) | (i << 5));
      chk(max_read_request_bytes_out, i < 6 ? 128 << i : 128);
      chk(max_payload_bytes_out, i < 6 ? 128 << i : 128);
    end
    $display("size code test done");
    for (e = 0; e < 16; e += 15)
    begin
      wr(12'h098, 2'h1, e);
      for (i = 0; i < 4; i++)
      begin
        v = 1 << i;
        ev(v, {v[2] & e[2], v[3] & e[3] | v[1] & e[1], v[0] & e[0]});
      end
    end
    ev(4'hf, 3'h7);
    @(posedge clk_in); #1 chk(cnt, 12'h232);
    $display("message test done");
    wr(12'h098, 2'h3, 16'h2000); fetch(100, 128); fetch(1000, 512);
    @(posedge clk_in) cache_line_size_in <= 0;
    fetch(100, 100);
    $display("fetch test done");
    give_verdict;
  end
endmodule // tb_pdc_device_control
bind pdc_device_control pdc_device_control_chk #(.LEN_W(LEN_W)) i_pdc_device_control_chk (.*);
